// >>> dual_wiper_bus_master.sv
/* Two-wire bus master model facing the target port.
   Assumes a pull-up on the data line, so a released line reads 1. */
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_bus_master (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Also serves as repeated start, entered with clock low
    task automatic start_cond();
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask : start_cond
    task automatic stop_cond();
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(3);
    endtask : stop_cond
    // Data moves only while clock low; line seen at both ends of the high phase
    task automatic one_bit(input logic b, output logic seen);
        logic first;
        sda_drv = b;
        tick(2);
        scl = 1'b1;
        tick(1);
        first = sda_line;
        tick(2);
        seen = first | sda_line;
        scl = 1'b0;
        tick(2);
    endtask : one_bit
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], s);
        end
        one_bit(1'b1, ack_n);
    endtask : send_byte
    task automatic read_byte(input logic ack_n, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b1, s);
            d[i] = s;
        end
        one_bit(ack_n, s);
    endtask : read_byte
endmodule : dual_wiper_bus_master
`default_nettype wire

// >>> dual_wiper_i2c_target_port.sv
/*
 * Two-wire target port of a dual 256-step potentiometer, with its wiper and access control registers.
 * It assumes that scl_in and sda_in are already synchronous to clk and that clk samples the bus many times
 * per bit; the board resolves sda from sda_oe with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_i2c_target_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic nonvolatile_write_pending,
    output logic [7:0] wiper_a,
    output logic [7:0] wiper_b,
    output logic volatile_only,
    output logic shutdown_n
);
    dual_wiper_pkg::port_state_type state_ff, nxt_state;
    dual_wiper_pkg::line_sample_type sample_ff, nxt_sample;
    dual_wiper_pkg::reg_file_type regs_ff, nxt_regs;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] tx_ff, nxt_tx;
    logic [7:0] ptr_ff, nxt_ptr;
    logic rw_ff, nxt_rw;
    logic first_ff, nxt_first;
    logic sda_oe_ff, nxt_oe;
    logic sda_out_ff;
    logic scl_rise, scl_fall, start_det, stop_det, addr_match;
    logic [7:0] rd_byte;

    // Changes of data under a high clock are conditions, never data
    assign start_det = sample_ff.scl && scl_in && sample_ff.sda && !sda_in;
    assign stop_det = sample_ff.scl && scl_in && !sample_ff.sda && sda_in;
    assign scl_rise = !sample_ff.scl && scl_in;
    assign scl_fall = sample_ff.scl && !scl_in;
    // Fixed 1010 nibble excludes the all-zero general call address
    assign addr_match = (shift_ff[7:1] == {dual_wiper_pkg::ADDR_FIXED, addr_strap_bit2, addr_strap_bit1,
                                           addr_strap_bit0});

    always_comb begin
        unique case (ptr_ff)
            dual_wiper_pkg::REG_WIPER_A: rd_byte = regs_ff.wiper_a;
            dual_wiper_pkg::REG_WIPER_B: rd_byte = regs_ff.wiper_b;
            dual_wiper_pkg::REG_ACR: begin
                rd_byte = regs_ff.access_control_reg;
                rd_byte[dual_wiper_pkg::ACR_WIP_BIT] = nonvolatile_write_pending;
            end
            default: rd_byte = dual_wiper_pkg::UNMAPPED_READ;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_sample = '{scl: scl_in, sda: sda_in};
        nxt_regs = regs_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_first = first_ff;
        nxt_oe = sda_oe_ff;
        if (stop_det) begin
            nxt_state = dual_wiper_pkg::ST_IDLE;
            nxt_oe = 1'b0;
        end else if (start_det) begin
            // Also a repeated start: a partial byte is simply dropped
            nxt_state = dual_wiper_pkg::ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
        end else begin
            unique case (state_ff)
                dual_wiper_pkg::ST_IDLE, dual_wiper_pkg::ST_IGNORE: begin
                    nxt_oe = 1'b0;
                end
                dual_wiper_pkg::ST_ADDR, dual_wiper_pkg::ST_WR_DATA: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_in};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == dual_wiper_pkg::BITS_PER_BYTE) begin
                        // Pull low on the falling edge so the line is settled before the ack high
                        if (state_ff == dual_wiper_pkg::ST_WR_DATA) begin
                            nxt_oe = 1'b1;
                            nxt_state = dual_wiper_pkg::ST_WR_ACK;
                        end else if (addr_match) begin
                            nxt_oe = 1'b1;
                            nxt_rw = shift_ff[0];
                            nxt_state = dual_wiper_pkg::ST_ADDR_ACK;
                        end else begin
                            nxt_state = dual_wiper_pkg::ST_IGNORE;
                        end
                    end
                end
                dual_wiper_pkg::ST_ADDR_ACK, dual_wiper_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        nxt_shift[0] = sda_in;
                    end else if (scl_fall) begin
                        nxt_oe = 1'b0;
                        nxt_cnt = 4'h0;
                        if (state_ff == dual_wiper_pkg::ST_ADDR_ACK && !rw_ff) begin
                            nxt_first = 1'b1;
                            nxt_state = dual_wiper_pkg::ST_WR_DATA;
                        end else if (state_ff == dual_wiper_pkg::ST_RD_ACK && shift_ff[0]) begin
                            // Master declined further data; wait for stop or start
                            nxt_state = dual_wiper_pkg::ST_IGNORE;
                        end else begin
                            nxt_tx = {rd_byte[6:0], 1'b0};
                            nxt_oe = !rd_byte[7];
                            nxt_ptr = ptr_ff + 8'h01;
                            nxt_state = dual_wiper_pkg::ST_RD_DATA;
                        end
                    end
                end
                dual_wiper_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        nxt_oe = 1'b0;
                        nxt_cnt = 4'h0;
                        nxt_state = dual_wiper_pkg::ST_WR_DATA;
                        // Byte takes effect only once its acknowledge clock has ended
                        if (first_ff) begin
                            nxt_ptr = shift_ff;
                            nxt_first = 1'b0;
                        end else begin
                            nxt_ptr = ptr_ff + 8'h01;
                            if (!nonvolatile_write_pending) begin
                                if (ptr_ff == dual_wiper_pkg::REG_WIPER_A) begin
                                    nxt_regs.wiper_a = shift_ff;
                                end
                                if (ptr_ff == dual_wiper_pkg::REG_WIPER_B) begin
                                    nxt_regs.wiper_b = shift_ff;
                                end
                                if (ptr_ff == dual_wiper_pkg::REG_ACR) begin
                                    nxt_regs.access_control_reg[dual_wiper_pkg::ACR_VOL_BIT] = shift_ff[dual_wiper_pkg::ACR_VOL_BIT];
                                    nxt_regs.access_control_reg[dual_wiper_pkg::ACR_SHDN_BIT] =
                                        shift_ff[dual_wiper_pkg::ACR_SHDN_BIT];
                                end
                            end
                        end
                    end
                end
                dual_wiper_pkg::ST_RD_DATA: begin
                    if (scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_ff == dual_wiper_pkg::BITS_PER_BYTE) begin
                            nxt_oe = 1'b0;
                            nxt_state = dual_wiper_pkg::ST_RD_ACK;
                        end else begin
                            nxt_oe = !tx_ff[7];
                            nxt_tx = {tx_ff[6:0], 1'b0};
                        end
                    end
                end
                // All eight codes are states, so no default
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= dual_wiper_pkg::ST_IDLE;
            sample_ff <= '{scl: 1'b1, sda: 1'b1};
            regs_ff <= '{wiper_a: dual_wiper_pkg::WIPER_RESET, wiper_b: dual_wiper_pkg::WIPER_RESET,
                         access_control_reg: dual_wiper_pkg::ACR_RESET};
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sample_ff <= nxt_sample;
            regs_ff <= nxt_regs;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            first_ff <= nxt_first;
            sda_oe_ff <= nxt_oe;
            sda_out_ff <= 1'b0;
        end
    end

    assign sda_out = sda_out_ff;
    assign sda_oe = sda_oe_ff;
    assign wiper_a = regs_ff.wiper_a;
    assign wiper_b = regs_ff.wiper_b;
    assign volatile_only = regs_ff.access_control_reg[dual_wiper_pkg::ACR_VOL_BIT];
    assign shutdown_n = regs_ff.access_control_reg[dual_wiper_pkg::ACR_SHDN_BIT];

    sequence addr_byte_done;
        state_ff == dual_wiper_pkg::ST_ADDR && scl_fall && cnt_ff == dual_wiper_pkg::BITS_PER_BYTE;
    endsequence

    sequence data_byte_done;
        state_ff == dual_wiper_pkg::ST_WR_DATA && scl_fall && cnt_ff == dual_wiper_pkg::BITS_PER_BYTE;
    endsequence

    a_start_opens_addr: assert property (@(posedge clk) disable iff (!rst_n)
        start_det && !stop_det |=> state_ff == dual_wiper_pkg::ST_ADDR && cnt_ff == 4'h0 && !sda_oe_ff)
        else $error("start did not open address phase");

    a_addr_ack_drive: assert property (@(posedge clk) disable iff (!rst_n)
        addr_byte_done and (addr_match && !start_det && !stop_det)
        |=> sda_oe_ff && state_ff == dual_wiper_pkg::ST_ADDR_ACK)
        else $error("matching address not acknowledged");

    a_mismatch_silent: assert property (@(posedge clk) disable iff (!rst_n)
        addr_byte_done and (!addr_match && !start_det && !stop_det) |=> !sda_oe_ff [*1] ##1 !sda_oe_ff)
        else $error("mismatched address drove the line");

    a_ack_held_high: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == dual_wiper_pkg::ST_WR_ACK || state_ff == dual_wiper_pkg::ST_ADDR_ACK) && scl_in
        && !scl_fall && !stop_det && !start_det |-> sda_oe_ff)
        else $error("acknowledge released during clock high");

    a_data_ack: assert property (@(posedge clk) disable iff (!rst_n)
        data_byte_done and (!start_det && !stop_det) |=> sda_oe_ff && state_ff == dual_wiper_pkg::ST_WR_ACK)
        else $error("data byte not acknowledged");

    a_release_after_ack: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_WR_ACK && scl_fall && !stop_det && !start_det |=> !sda_oe_ff)
        else $error("line not released after acknowledge");

    a_stop_to_idle: assert property (@(posedge clk) disable iff (!rst_n)
        stop_det |=> state_ff == dual_wiper_pkg::ST_IDLE && !sda_oe_ff)
        else $error("stop did not return to idle");

    a_one_bit_per_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_WR_DATA && scl_rise && !start_det && !stop_det
        |=> cnt_ff == $past(cnt_ff) + 4'h1 && shift_ff[0] == $past(sda_in))
        else $error("bit not sampled on clock rise");

    a_pending_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        nonvolatile_write_pending |=> $stable(regs_ff))
        else $error("register changed while write pending");

    a_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
        !sda_out_ff)
        else $error("data line driven high");

    a_rd_ack_release: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_RD_DATA && scl_fall && cnt_ff == dual_wiper_pkg::BITS_PER_BYTE
        && !start_det && !stop_det |=> !sda_oe_ff && state_ff == dual_wiper_pkg::ST_RD_ACK)
        else $error("read byte did not release the line");

    a_ignore_silent: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_IGNORE |-> !sda_oe_ff)
        else $error("ignored transfer drove the line");

    a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_IDLE |-> !sda_oe_ff)
        else $error("idle port drove the line");

    a_partial_dropped: assert property (@(posedge clk) disable iff (!rst_n)
        (start_det || stop_det) |=> regs_ff == $past(regs_ff))
        else $error("partial byte changed a register");

    a_wiper_a_store: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_WR_ACK && scl_fall && !first_ff && !nonvolatile_write_pending
        && ptr_ff == dual_wiper_pkg::REG_WIPER_A && !start_det && !stop_det |=> wiper_a == $past(shift_ff))
        else $error("acknowledged byte not stored in wiper a");

    a_wiper_b_store: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_WR_ACK && scl_fall && !first_ff && !nonvolatile_write_pending
        && ptr_ff == dual_wiper_pkg::REG_WIPER_B && !start_det && !stop_det |=> wiper_b == $past(shift_ff))
        else $error("acknowledged byte not stored in wiper b");

    a_pointer_load: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_WR_ACK && scl_fall && !start_det && !stop_det
        |=> ptr_ff == ($past(first_ff) ? $past(shift_ff) : $past(ptr_ff) + 8'h01))
        else $error("register pointer not loaded or advanced");

    a_addr_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == dual_wiper_pkg::ST_ADDR && scl_rise && !start_det && !stop_det
        |=> shift_ff == {$past(shift_ff[6:0]), $past(sda_in)})
        else $error("address bit not shifted in at the bottom");
endmodule : dual_wiper_i2c_target_port
`default_nettype wire

// >>> dual_wiper_pkg.sv
/*
 * Constants, state encoding and carrier types shared by the two-wire target port.
 * It assumes that the target port module refers to every item with the package name in front.
 */
`default_nettype none
package dual_wiper_pkg;
    // Fixed upper nibble of the target address
    localparam logic [3:0] ADDR_FIXED = 4'hA;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] REG_WIPER_A = 8'h00;
    localparam logic [7:0] REG_WIPER_B = 8'h01;
    localparam logic [7:0] REG_ACR = 8'h10;
    // Midscale step: equal resistance on both sides
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [7:0] ACR_RESET = 8'h40;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int ACR_VOL_BIT = 7;
    localparam int ACR_SHDN_BIT = 6;
    localparam int ACR_WIP_BIT = 5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } port_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_sample_type;

    typedef struct packed {
        logic [7:0] wiper_a;
        logic [7:0] wiper_b;
        logic [7:0] access_control_reg;
    } reg_file_type;
endpackage : dual_wiper_pkg
`default_nettype wire

// >>> tb_top.sv
/* Self-checking bench for the two-wire target port.
   Assumes the bus master model; data line resolved here with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk;
    logic rst_n;
    logic scl;
    logic sda_drv;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    logic [2:0] strap;
    logic pend;
    logic [7:0] wiper_a;
    logic [7:0] wiper_b;
    logic volatile_only;
    logic shutdown_n;
    int err_total;
    int comparisons;
    // Wired-AND: a driven high from the port would show up as a missing ack
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    dual_wiper_bus_master master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    dual_wiper_i2c_target_port uut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .nonvolatile_write_pending(pend), .wiper_a(wiper_a),
        .wiper_b(wiper_b), .volatile_only(volatile_only), .shutdown_n(shutdown_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] ptr, input logic [15:0] dat, input int n);
        logic a;
        master.start_cond();
        master.send_byte({4'hA, strap, 1'b0}, a);
        check("address ack", 8'h00, {7'h00, a});
        master.send_byte(ptr, a);
        check("pointer ack", 8'h00, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            master.send_byte(dat[15-8*i -: 8], a);
            check("data ack", 8'h00, {7'h00, a});
        end
        master.stop_cond();
    endtask : wr
    task automatic rd(input logic [7:0] ptr, input logic [15:0] exp, input int n);
        logic a;
        logic [7:0] d;
        master.start_cond();
        master.send_byte({4'hA, strap, 1'b0}, a);
        master.send_byte(ptr, a);
        master.start_cond();
        master.send_byte({4'hA, strap, 1'b1}, a);
        check("read address ack", 8'h00, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            master.read_byte(i == n - 1, d);
            check("read data", exp[15-8*i -: 8], d);
        end
        master.stop_cond();
    endtask : rd
    task automatic t_reset();
        check("wiper_a", 8'h80, wiper_a);
        check("wiper_b", 8'h80, wiper_b);
        check("control bits", 8'h01, {6'h00, volatile_only, shutdown_n});
    endtask : t_reset
    task automatic t_write();
        strap = 3'h5;
        wr(8'h01, 16'h3C00, 1);
        check("wiper_b", 8'h3C, wiper_b);
        strap = 3'h2;
        wr(8'h00, 16'h5AA5, 2);
        check("wiper_a", 8'h5A, wiper_a);
        check("wiper_b", 8'hA5, wiper_b);
    endtask : t_write
    task automatic t_refuse();
        logic a;
        logic [7:0] bad [3];
        bad = '{8'h00, {4'hA, ~strap, 1'b0}, {4'h2, strap, 1'b0}};
        foreach (bad[k]) begin
            master.start_cond();
            master.send_byte(bad[k], a);
            check("refused address ack", 8'h01, {7'h00, a});
            master.send_byte(8'h00, a);
            check("ignored byte ack", 8'h01, {7'h00, a});
            master.send_byte(8'h11, a);
            master.stop_cond();
        end
        check("wiper_a", 8'h5A, wiper_a);
    endtask : t_refuse
    task automatic t_partial();
        logic a;
        logic s;
        for (int k = 0; k < 2; k++) begin
            master.start_cond();
            master.send_byte({4'hA, strap, 1'b0}, a);
            master.send_byte(8'(k), a);
            for (int i = 0; i < 4 + k; i++) begin
                master.one_bit(1'b0, s);
            end
            if (k == 1) begin
                master.start_cond();
            end
            master.stop_cond();
        end
        check("wiper_a", 8'h5A, wiper_a);
        check("wiper_b", 8'hA5, wiper_b);
    endtask : t_partial
    task automatic t_pending();
        pend = 1'b1;
        wr(8'h00, 16'h1200, 1);
        check("wiper_a", 8'h5A, wiper_a);
        wr(8'h10, 16'hC000, 1);
        check("volatile_only", 8'h00, {7'h00, volatile_only});
        rd(8'h10, 16'h6000, 1);
        pend = 1'b0;
    endtask : t_pending
    task automatic t_control();
        wr(8'h10, 16'hFF00, 1);
        check("control bits", 8'h03, {6'h00, volatile_only, shutdown_n});
        rd(8'h0F, 16'h00C0, 2);
        wr(8'h10, 16'h0000, 1);
        check("control bits", 8'h00, {6'h00, volatile_only, shutdown_n});
        rd(8'h10, 16'h0000, 1);
        rd(8'h00, 16'h5AA5, 2);
    endtask : t_control
    // Reset in mid-run with the bus idle; wipers must fall back to midscale
    task automatic t_midreset();
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check("wiper_a", 8'h80, wiper_a);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        wr(8'h01, 16'h7F00, 1);
        check("wiper_b", 8'h7F, wiper_b);
    endtask : t_midreset
    initial begin
        rst_n = 1'b0;
        strap = 3'h0;
        pend = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_write();
        t_refuse();
        t_partial();
        t_pending();
        t_control();
        t_midreset();
        wrap_up();
    end
    // About 3800 cycles expected; generous margin
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
